// ===== shared/usdf_defs.vh
// constants of the shadow data port slice: addresses, bits, resets
// assumes APB byte addresses, one 32-bit word per register
`ifndef USDF_DEFS_VH
`define USDF_DEFS_VH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define USDF_SHADOW_BASE 32'h50001130
`define USDF_SHADOW_LAST 32'h5000116c
`define USDF_FAR_ADDR    32'h50001170
`define USDF_FCR_ADDR    32'h50001180
`define USDF_LSR_ADDR    32'h50001184
`define USDF_IST_ADDR    32'h50001188
`define USDF_IMSK_ADDR   32'h5000118c

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define USDF_FAR_MODE_BIT 0
`define USDF_FCR_EN_BIT   0
`define USDF_LSR_DR_BIT   0
`define USDF_LSR_RFF_BIT  4
`define USDF_LSR_TX_HOLDING_EMPTY_FLAG_BIT 5
`define USDF_LSR_TFF_BIT  6
`define USDF_IRQ_OVR_BIT  0
`define USDF_IRQ_TXL_BIT  1
`define USDF_IRQ_W        2
`define USDF_DATA_W       8

// ------------------------------------------------------------
// sizes and reset values
// ------------------------------------------------------------
`define USDF_FIFO_DEPTH 16
`define USDF_FIFO_AW    4
`define USDF_FAR_RST    1'b0
`define USDF_FCR_RST    1'b0
`define USDF_IMSK_RST   2'h0
`define USDF_DATA_RST   8'h00

`endif

// ===== hw/usdf_fifo.v
// synchronous fifo with pointer clear, head shown combinationally
// assumes DEPTH equals two to the power AW
module usdf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire             i_clear,
  input  wire             i_push,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_pop,
  output wire [WIDTH-1:0] o_data,
  output wire             o_empty,
  output wire             o_full
);
  localparam [AW:0] DEPTH_C = DEPTH;

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      cnt_r;
  wire            pop_ok;
  wire            push_ok;

  assign o_empty = (cnt_r == {(AW+1){1'b0}});
  assign o_full  = (cnt_r == DEPTH_C);
  assign o_data  = mem_r[rd_ptr_r];
  assign pop_ok  = i_pop & ~o_empty;
  assign push_ok = i_push & (~o_full | pop_ok);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  always @(posedge i_clk) begin
    if (push_ok & ~i_clear) begin
      mem_r[wr_ptr_r] <= i_data;
    end
  end

  // ------------------------------------------------------------
  // pointers and count
  // ------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r    <= {(AW+1){1'b0}};
    end else if (i_clear) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r    <= {(AW+1){1'b0}};
    end else begin
      if (push_ok) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop_ok) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push_ok & ~pop_ok) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop_ok & ~push_ok) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // usdf_fifo

// ===== hw/usdf_irq.v
// sticky event status, write one to clear, mask, one level irq
// assumes events are one-cycle pulses on the same clock
module usdf_irq #(
  parameter W = 2
) (
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire [W-1:0] i_event,
  input  wire         i_clr_we,
  input  wire [W-1:0] i_clr_data,
  input  wire         i_mask_we,
  input  wire [W-1:0] i_mask_data,
  output reg  [W-1:0] o_status,
  output reg  [W-1:0] o_mask,
  output reg          o_irq
);
  reg [W-1:0] status_nxt;
  reg [W-1:0] mask_nxt;

  // set wins over a clear in the same cycle
  always @* begin
    status_nxt = o_status & ~(i_clr_we ? i_clr_data : {W{1'b0}});
    status_nxt = status_nxt | i_event;
    mask_nxt   = i_mask_we ? i_mask_data : o_mask;
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_status <= {W{1'b0}};
      o_mask   <= {W{1'b0}};
      o_irq    <= 1'b0;
    end else begin
      o_status <= status_nxt;
      o_mask   <= mask_nxt;
      o_irq    <= |(status_nxt & mask_nxt);
    end
  end
endmodule // usdf_irq

// ===== hw/usdf_top.v
// shadow data port of a serial port with rx/tx fifos and test access
// assumes an APB master and serial logic on the same clock
`include "usdf_defs.vh"

module usdf_top #(
  parameter FIFO_ACCESS = 1,
  parameter FIFO_DEPTH  = `USDF_FIFO_DEPTH,
  parameter FIFO_AW     = `USDF_FIFO_AW
) (
  input  wire        I_REF_CLK,
  input  wire        I_SYS_RST,
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [31:0] I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output reg         O_PREADY,
  output reg         O_PSLVERR,
  input  wire        I_RX_VALID,
  input  wire [7:0]  I_RX_DATA,
  input  wire        I_TX_TAKE,
  output reg         O_TX_VALID,
  output reg  [7:0]  O_TX_DATA,
  output reg         O_RX_DATA_READY,
  output reg         O_TX_HOLD_EMPTY,
  output reg         O_FIFO_EN,
  output wire        O_IRQ
);
  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function is_shadow;
    input [31:0] a;
    begin
      is_shadow = (a >= `USDF_SHADOW_BASE) &&
                  (a <= `USDF_SHADOW_LAST) &&
                  (a[1:0] == 2'h0);
    end
  endfunction

  function is_mapped;
    input [31:0] a;
    begin
      is_mapped = is_shadow(a) ||
                  (a == `USDF_FAR_ADDR) ||
                  (a == `USDF_FCR_ADDR) ||
                  (a == `USDF_LSR_ADDR) ||
                  (a == `USDF_IST_ADDR) ||
                  (a == `USDF_IMSK_ADDR);
    end
  endfunction

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  reg                   test_r;
  reg                   fifo_en_r;
  reg  [7:0]            rbr_r;
  reg                   rbr_full_r;
  reg  [7:0]            thr_r;
  reg                   thr_empty_r;
  reg                   mode_nxt;
  reg  [31:0]           rd_val;
  reg  [31:0]           lsr_val;
  wire                  acc;
  wire                  first_acc;
  wire                  done;
  wire                  wr_done;
  wire                  rd_done;
  wire                  sh_wr;
  wire                  sh_rd;
  wire                  far_wr;
  wire                  fcr_wr;
  wire                  ist_wr;
  wire                  imsk_wr;
  wire                  mode_flip;
  wire [7:0]            rx_head;
  wire                  rx_empty;
  wire                  rx_full;
  wire                  rx_push;
  wire                  rx_pop;
  wire [7:0]            rx_in;
  wire [7:0]            tx_head;
  wire                  tx_empty;
  wire                  tx_full;
  wire                  tx_push;
  wire                  tx_pop;
  wire                  load_stage;
  wire                  thr_wr;
  wire                  rbr_serial;
  wire                  rbr_test_wr;
  wire                  rbr_read;
  wire                  data_ready;
  wire                  hold_empty;
  wire                  ev_overrun;
  wire                  ev_tx_lost;
  wire [`USDF_IRQ_W-1:0] irq_event;
  wire [`USDF_IRQ_W-1:0] irq_status;
  wire [`USDF_IRQ_W-1:0] irq_mask;

  // ------------------------------------------------------------
  // apb handshake: one wait state, effects at the completing edge
  // ------------------------------------------------------------
  assign acc       = I_PSEL & I_PENABLE;
  assign first_acc = acc & ~O_PREADY;
  assign done      = acc & O_PREADY;
  assign wr_done   = done & I_PWRITE;
  assign rd_done   = done & ~I_PWRITE;

  assign sh_wr   = wr_done & is_shadow(I_PADDR);
  assign sh_rd   = rd_done & is_shadow(I_PADDR);
  assign far_wr  = wr_done & (I_PADDR == `USDF_FAR_ADDR);
  assign fcr_wr  = wr_done & (I_PADDR == `USDF_FCR_ADDR);
  assign ist_wr  = wr_done & (I_PADDR == `USDF_IST_ADDR);
  assign imsk_wr = wr_done & (I_PADDR == `USDF_IMSK_ADDR);

  // ------------------------------------------------------------
  // test access mode bit
  // ------------------------------------------------------------
  always @* begin
    mode_nxt = test_r;
    if (far_wr && (FIFO_ACCESS != 0)) begin
      mode_nxt = I_PWDATA[`USDF_FAR_MODE_BIT];
    end
  end

  assign mode_flip = (mode_nxt != test_r);

  always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      test_r    <= `USDF_FAR_RST;
      fifo_en_r <= `USDF_FCR_RST;
    end else begin
      test_r <= mode_nxt;
      if (fcr_wr) begin
        fifo_en_r <= I_PWDATA[`USDF_FCR_EN_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // receive fifo
  // ------------------------------------------------------------
  // serial arrival has priority over a test-mode master write
  assign rx_in   = I_RX_VALID ? I_RX_DATA : I_PWDATA[7:0];
  assign rx_push = fifo_en_r &
                   (I_RX_VALID | (test_r & sh_wr));
  assign rx_pop  = fifo_en_r & ~test_r & sh_rd;

  usdf_fifo #(
    .WIDTH (`USDF_DATA_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_rx_fifo (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_SYS_RST),
    .i_clear (mode_flip),
    .i_push  (rx_push),
    .i_data  (rx_in),
    .i_pop   (rx_pop),
    .o_data  (rx_head),
    .o_empty (rx_empty),
    .o_full  (rx_full)
  );

  // ------------------------------------------------------------
  // transmit fifo
  // ------------------------------------------------------------
  assign tx_push = fifo_en_r & ~test_r & sh_wr;
  assign tx_pop  = fifo_en_r &
                   (test_r ? sh_rd : load_stage);

  usdf_fifo #(
    .WIDTH (`USDF_DATA_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_tx_fifo (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_SYS_RST),
    .i_clear (mode_flip),
    .i_push  (tx_push),
    .i_data  (I_PWDATA[7:0]),
    .i_pop   (tx_pop),
    .o_data  (tx_head),
    .o_empty (tx_empty),
    .o_full  (tx_full)
  );

  // ------------------------------------------------------------
  // receive buffer without fifo
  // ------------------------------------------------------------
  assign rbr_serial  = ~fifo_en_r & I_RX_VALID;
  assign rbr_test_wr = ~fifo_en_r & test_r & sh_wr;
  assign rbr_read    = ~fifo_en_r & ~test_r & sh_rd;

  always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rbr_r      <= `USDF_DATA_RST;
      rbr_full_r <= 1'b0;
    end else if (rbr_serial) begin
      rbr_r      <= I_RX_DATA;
      rbr_full_r <= 1'b1;
    end else if (rbr_test_wr) begin
      rbr_r      <= I_PWDATA[7:0];
      rbr_full_r <= 1'b1;
    end else if (rbr_read) begin
      rbr_full_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // transmit holding register without fifo
  // ------------------------------------------------------------
  assign thr_wr = ~fifo_en_r & ~test_r & sh_wr;

  always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      thr_r       <= `USDF_DATA_RST;
      thr_empty_r <= 1'b1;
    end else if (thr_wr) begin
      thr_r       <= I_PWDATA[7:0];
      thr_empty_r <= 1'b0;
    end else if (load_stage & ~fifo_en_r) begin
      thr_empty_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // character handed to the transmitter
  // ------------------------------------------------------------
  // held back in test mode so the master can read the tx side
  assign load_stage = ~test_r & ~O_TX_VALID &
                      (fifo_en_r ? ~tx_empty : ~thr_empty_r);

  always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_TX_VALID <= 1'b0;
      O_TX_DATA  <= `USDF_DATA_RST;
    end else if (load_stage) begin
      O_TX_VALID <= 1'b1;
      O_TX_DATA  <= fifo_en_r ? tx_head : thr_r;
    end else if (I_TX_TAKE) begin
      O_TX_VALID <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  assign data_ready = fifo_en_r ? ~rx_empty : rbr_full_r;
  assign hold_empty = fifo_en_r ? tx_empty : thr_empty_r;

  always @* begin
    lsr_val = 32'h00000000;
    lsr_val[`USDF_LSR_DR_BIT]   = data_ready;
    lsr_val[`USDF_LSR_RFF_BIT]  = fifo_en_r & rx_full;
    lsr_val[`USDF_LSR_TX_HOLDING_EMPTY_FLAG_BIT] = hold_empty;
    lsr_val[`USDF_LSR_TFF_BIT]  = fifo_en_r & tx_full;
  end

  always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_RX_DATA_READY <= 1'b0;
      O_TX_HOLD_EMPTY <= 1'b1;
      O_FIFO_EN       <= `USDF_FCR_RST;
    end else begin
      O_RX_DATA_READY <= data_ready;
      O_TX_HOLD_EMPTY <= hold_empty;
      O_FIFO_EN       <= fifo_en_r;
    end
  end

  // ------------------------------------------------------------
  // events and interrupt
  // ------------------------------------------------------------
  assign ev_overrun = I_RX_VALID &
                      (fifo_en_r ? (rx_full & ~rx_pop)
                                 : (rbr_full_r & ~rbr_read));
  assign ev_tx_lost = tx_push & tx_full & ~tx_pop;

  assign irq_event[`USDF_IRQ_OVR_BIT] = ev_overrun;
  assign irq_event[`USDF_IRQ_TXL_BIT] = ev_tx_lost;

  usdf_irq #(
    .W (`USDF_IRQ_W)
  ) u_irq (
    .i_clk       (I_REF_CLK),
    .i_rst       (I_SYS_RST),
    .i_event     (irq_event),
    .i_clr_we    (ist_wr),
    .i_clr_data  (I_PWDATA[`USDF_IRQ_W-1:0]),
    .i_mask_we   (imsk_wr),
    .i_mask_data (I_PWDATA[`USDF_IRQ_W-1:0]),
    .o_status    (irq_status),
    .o_mask      (irq_mask),
    .o_irq       (O_IRQ)
  );

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always @* begin
    rd_val = 32'h00000000;
    if (is_shadow(I_PADDR)) begin
      if (test_r) begin
        rd_val[7:0] = fifo_en_r ? tx_head : thr_r;
      end else begin
        rd_val[7:0] = fifo_en_r ? rx_head : rbr_r;
      end
    end else if (I_PADDR == `USDF_FAR_ADDR) begin
      rd_val[`USDF_FAR_MODE_BIT] = test_r;
    end else if (I_PADDR == `USDF_FCR_ADDR) begin
      rd_val[`USDF_FCR_EN_BIT] = fifo_en_r;
    end else if (I_PADDR == `USDF_LSR_ADDR) begin
      rd_val = lsr_val;
    end else if (I_PADDR == `USDF_IST_ADDR) begin
      rd_val[`USDF_IRQ_W-1:0] = irq_status;
    end else if (I_PADDR == `USDF_IMSK_ADDR) begin
      rd_val[`USDF_IRQ_W-1:0] = irq_mask;
    end
  end

  // ------------------------------------------------------------
  // apb answer registers
  // ------------------------------------------------------------
  always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= 32'h00000000;
    end else begin
      O_PREADY  <= first_acc;
      O_PSLVERR <= first_acc & ~is_mapped(I_PADDR);
      if (first_acc) begin
        O_PRDATA <= I_PWRITE ? 32'h00000000 : rd_val;
      end
    end
  end
endmodule // usdf_top

// ===== verif/usdf_monitor.sv
// assertion checker of the shadow data port slice, top ports only
// assumes one clock domain; bound to the top by the line at the foot
`include "usdf_defs.vh"
module usdf_monitor #(
  parameter FIFO_DEPTH = 16
) (
  input logic        I_REF_CLK,
  input logic        I_SYS_RST,
  input logic        I_PSEL,
  input logic        I_PENABLE,
  input logic        I_PWRITE,
  input logic [31:0] I_PADDR,
  input logic [31:0] I_PWDATA,
  input logic [31:0] O_PRDATA,
  input logic        O_PREADY,
  input logic        O_PSLVERR,
  input logic        I_RX_VALID,
  input logic [7:0]  I_RX_DATA,
  input logic        I_TX_TAKE,
  input logic        O_TX_VALID,
  input logic [7:0]  O_TX_DATA,
  input logic        O_RX_DATA_READY,
  input logic        O_TX_HOLD_EMPTY,
  input logic        O_FIFO_EN,
  input logic        O_IRQ
);
  logic mode_r;
  logic shadow;
  logic mapped;
  // ------------------------------------------------------------
  // address decode and mode tracking
  // ------------------------------------------------------------
  assign shadow = I_PADDR >= `USDF_SHADOW_BASE &&
                  I_PADDR <= `USDF_SHADOW_LAST &&
                  I_PADDR[1:0] == 2'h0;
  assign mapped = shadow || I_PADDR == `USDF_FAR_ADDR ||
                  I_PADDR == `USDF_FCR_ADDR ||
                  I_PADDR == `USDF_LSR_ADDR ||
                  I_PADDR == `USDF_IST_ADDR ||
                  I_PADDR == `USDF_IMSK_ADDR;
  always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) mode_r <= 1'h0;
    else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE &&
             I_PADDR == `USDF_FAR_ADDR) mode_r <= I_PWDATA[0];
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_wait;
    I_PSEL && I_PENABLE && !O_PREADY;
  endsequence
  sequence s_done;
    I_PSEL && I_PENABLE && O_PREADY;
  endsequence
  sequence s_tx_wr;
    s_done ##0 (I_PWRITE && shadow && !mode_r);
  endsequence
  chk_ready_wait: assert property (s_wait |=> O_PREADY)
    else $error("ready late");
  chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready too long");
  chk_err_addr: assert property (s_done |-> O_PSLVERR == !mapped)
    else $error("error flag wrong");
  chk_err_alone: assert property (O_PSLVERR |-> O_PREADY && I_PSEL)
    else $error("error without ready");
  chk_read_upper: assert property (s_done ##0 !I_PWRITE |->
    O_PRDATA[31:8] == 24'h0) else $error("upper read bits set");
  chk_rx_ready: assert property (I_RX_VALID && !I_PSEL |->
    ##2 O_RX_DATA_READY) else $error("data ready missing");
  chk_tx_load: assert property (s_tx_wr ##0 !O_TX_VALID |->
    ##[1:3] O_TX_VALID) else $error("tx char not loaded");
  chk_tx_holding_empty_flag_fall: assert property (s_tx_wr ##0 (O_TX_VALID &&
    !I_TX_TAKE) |-> ##[1:3] !O_TX_HOLD_EMPTY)
    else $error("holding empty stayed set");
  chk_tx_hold: assert property (O_TX_VALID && !I_TX_TAKE |=>
    O_TX_VALID && $stable(O_TX_DATA)) else $error("tx char changed");
  chk_take_clear: assert property (O_TX_VALID && I_TX_TAKE |=>
    !O_TX_VALID) else $error("tx valid not cleared");
endmodule // usdf_monitor
bind usdf_top usdf_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (.*);

// ===== verif/usdf_serial_model.sv
// serial side stand-in: injects received chars, takes tx chars
// assumes the port clock; take pace set by take_en and lag
module usdf_serial_model (
  input  logic       i_clk,
  output logic       o_rx_valid,
  output logic [7:0] o_rx_data,
  input  logic       i_tx_valid,
  input  logic [7:0] i_tx_data,
  output logic       o_tx_take
);
  timeunit 1ns;
  timeprecision 1ns;
  bit         take_en = 1'h0;
  int         lag = 0;
  int         wait_r = 0;
  logic [7:0] txq[$];
  initial begin
    o_rx_valid = 1'h0;
    o_rx_data = 8'h00;
    o_tx_take = 1'h0;
  end
  // ------------------------------------------------------------
  // rx pulse, idle data inverted, and tx take
  // ------------------------------------------------------------
  task automatic send(input logic [7:0] d);
    @(posedge i_clk);
    o_rx_valid <= 1'h1;
    o_rx_data <= d;
    @(posedge i_clk);
    o_rx_valid <= 1'h0;
    o_rx_data <= ~d;
  endtask
  always @(posedge i_clk) begin
    o_tx_take <= 1'h0;
    if (take_en && i_tx_valid && !o_tx_take) begin
      if (wait_r < lag) wait_r <= wait_r + 1;
      else begin
        o_tx_take <= 1'h1;
        txq.push_back(i_tx_data);
        wait_r <= 0;
      end
    end
  end
endmodule // usdf_serial_model

// ===== verif/tb_top.sv
// self-checking bench of the shadow data port slice
// assumes the monitor and serial model files are compiled first
`include "usdf_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] far_a = `USDF_FAR_ADDR;
  localparam logic [31:0] fcr_a = `USDF_FCR_ADDR;
  localparam logic [31:0] lsr_a = `USDF_LSR_ADDR;
  localparam logic [31:0] ist_a = `USDF_IST_ADDR;
  localparam logic [31:0] msk_a = `USDF_IMSK_ADDR;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, b;
  logic [31:0] seed = 32'h04ca;
  logic        pready, pslverr, err, rxv, take, txv, rdy, tx_holding_empty_flag, fen, irq;
  logic [7:0]  rxd, txd;
  logic [7:0]  q[$];
  int          fail_count = 0;
  int          check_count = 0;
  always #5 clk = ~clk;
  usdf_top i_dut (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_RX_VALID(rxv), .I_RX_DATA(rxd), .I_TX_TAKE(take),
    .O_TX_VALID(txv), .O_TX_DATA(txd), .O_RX_DATA_READY(rdy),
    .O_TX_HOLD_EMPTY(tx_holding_empty_flag), .O_FIFO_EN(fen), .O_IRQ(irq)
  );
  usdf_serial_model u_ser (
    .i_clk(clk), .o_rx_valid(rxv), .o_rx_data(rxd),
    .i_tx_valid(txv), .i_tx_data(txd), .o_tx_take(take)
  );
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] shad();
    logic [31:0] r;
    r = xs();
    return `USDF_SHADOW_BASE + {26'h0, r[3:0], 2'h0};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rchk(input logic [31:0] a, exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic drain(input int n);
    int k = 0;
    u_ser.take_en <= 1'h1;
    while (u_ser.txq.size() < n && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (k >= 400) begin
      fail_count++;
      summarize();
    end
    for (int i = 0; i < n; i++) begin
      chk({24'h0, u_ser.txq[i]}, {24'h0, q[i]});
    end
    u_ser.txq.delete();
    u_ser.take_en <= 1'h0;
    q.delete();
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    rchk(far_a, 32'h0);
    rchk(lsr_a, 32'h20);
    apb(1'h1, lsr_a, 32'hff);
    rchk(lsr_a, 32'h20);
    apb(1'h0, 32'h50001190, 32'h0);
    chk({31'h0, err}, 32'h1);
    b = xs();
    u_ser.send(b[7:0]);
    u_ser.send(b[15:8]);
    rchk(shad(), {24'h0, b[15:8]});
    rchk(ist_a, 32'h1);
    apb(1'h1, msk_a, 32'h3);
    rchk(lsr_a, 32'h20);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, msk_a, 32'h0);
    rchk(msk_a, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, ist_a, 32'h3);
    rchk(ist_a, 32'h0);
    b = xs();
    q = {b[7:0], b[23:16]};
    apb(1'h1, shad(), b);
    apb(1'h1, shad(), b >> 8);
    rchk(lsr_a, 32'h0);
    apb(1'h1, shad(), b >> 16);
    apb(1'h1, far_a, 32'h1);
    rchk(far_a, 32'h1);
    rchk(shad(), {24'h0, b[23:16]});
    apb(1'h1, shad(), ~b);
    rchk(lsr_a, 32'h1);
    apb(1'h1, far_a, 32'h0);
    rchk(shad(), {24'h0, ~b[7:0]});
    drain(2);
    apb(1'h1, fcr_a, 32'h1);
    rchk(fcr_a, 32'h1);
    chk({31'h0, fen}, 32'h1);
    for (int i = 0; i < 17; i++) begin
      b = xs();
      u_ser.send(b[7:0]);
      if (i < 16) q.push_back(b[7:0]);
    end
    rchk(lsr_a, 32'h31);
    rchk(ist_a, 32'h1);
    for (int i = 0; i < 16; i++) rchk(shad(), {24'h0, q[i]});
    rchk(lsr_a, 32'h20);
    q.delete();
    apb(1'h1, ist_a, 32'h1);
    for (int i = 0; i < 18; i++) begin
      b = xs();
      apb(1'h1, shad(), b);
      if (i < 17) q.push_back(b[7:0]);
    end
    rchk(lsr_a, 32'h40);
    rchk(ist_a, 32'h2);
    apb(1'h1, ist_a, 32'h2);
    b = xs();
    u_ser.lag <= b[1:0];
    drain(17);
    u_ser.lag <= 0;
    b = xs();
    q = {b[7:0]};
    apb(1'h1, shad(), b);
    apb(1'h1, shad(), b >> 8);
    u_ser.send(b[23:16]);
    rchk(lsr_a, 32'h1);
    apb(1'h1, far_a, 32'h1);
    rchk(lsr_a, 32'h20);
    apb(1'h1, shad(), b >> 24);
    rchk(lsr_a, 32'h21);
    apb(1'h1, far_a, 32'h0);
    rchk(lsr_a, 32'h20);
    drain(1);
    summarize();
  end
endmodule // tb_top
